// File: src/flash_seq_pkg.sv
// Shared constants and types for the flash command sequencer and its bus master.
package flash_seq_pkg;

    // ------------------------------------------------------------
    // Access modes
    // ------------------------------------------------------------
    localparam logic [1:0] SIZE_ROM = 2'h2;
    localparam logic [1:0] SIZE_PROG = 2'h1;
    localparam logic [1:0] SIZE_RESET = 2'h2;

    // ------------------------------------------------------------
    // Command addresses and codes
    // ------------------------------------------------------------
    localparam logic [15:0] CMD_ADDR_A = 16'h1550;
    localparam logic [15:0] CMD_ADDR_B = 16'h0aa8;
    localparam logic [7:0] CODE_UNLOCK1 = 8'haa;
    localparam logic [7:0] CODE_UNLOCK2 = 8'h55;
    localparam logic [7:0] CODE_PROGRAM = 8'ha0;
    localparam logic [7:0] CODE_ERASE = 8'h80;
    localparam logic [7:0] CODE_CHIP = 8'h10;
    localparam logic [7:0] CODE_SECTOR = 8'h30;
    localparam logic [7:0] CODE_RESET = 8'hf0;
    localparam logic [7:0] CODE_SUSPEND = 8'hb0;
    localparam logic [7:0] CODE_RESUME = 8'h30;

    // ------------------------------------------------------------
    // Address ranges
    // ------------------------------------------------------------
    localparam logic [15:0] FLASH_HI_FIRST = 16'h0000;
    localparam logic [15:0] FLASH_HI_LAST = 16'h0010;
    localparam logic [31:0] SECURITY_BASE = 32'h0010_0000;
    localparam logic [31:0] TRIM_BASE = 32'h0010_1004;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int SECTOR_WAIT_US = 35;
    localparam int SECTOR_WAIT_CYC = SECTOR_WAIT_US * CLK_MHZ;
    localparam int ALGO_CYC = 16;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ALG_IDLE = 3'h0,
        ALG_PROGRAM = 3'h1,
        ALG_CHIP = 3'h2,
        ALG_SECT_WAIT = 3'h3,
        ALG_SECT = 3'h4,
        ALG_SUSP = 3'h5
    } alg_state_t;

    // Seven check bits over a 32-bit word: six Hamming bits plus overall parity.
    function automatic logic [6:0] ecc_gen(input logic [31:0] d);
        logic [6:0] c;
        logic [37:0] cw;
        int k;
        c = 7'h00;
        cw = 38'h0;
        k = 0;
        for (int p = 1; p <= 38; p++) begin
            if ((p & (p - 1)) != 0) begin
                cw[p-1] = d[k];
                k++;
            end
        end
        for (int b = 0; b < 6; b++) begin
            for (int p = 1; p <= 38; p++) begin
                if (((p >> b) & 1) == 1) begin
                    c[b] = c[b] ^ cw[p-1];
                end
            end
        end
        c[6] = ^d ^ ^c[5:0];
        return c;
    endfunction

    // Corrects one flipped data bit from the stored check bits; pure logic, no cycles.
    function automatic logic [31:0] ecc_fix(input logic [31:0] d, input logic [6:0] c);
        logic [5:0] syn;
        logic [31:0] o;
        int k;
        // Only the six Hamming bits locate the error; the parity bit is dropped on purpose.
        syn = 6'(ecc_gen(d) ^ c);
        o = d;
        k = 0;
        for (int p = 1; p <= 38; p++) begin
            if ((p & (p - 1)) != 0) begin
                if (syn == 6'(p)) begin
                    o[k] = ~d[k];
                end
                k++;
            end
        end
        return o;
    endfunction

endpackage

// File: src/flash_bus_if.sv
// Bus between the CPU-side master and the flash command sequencer.
`timescale 1ns/10ps
`default_nettype none
interface flash_bus_if;
    logic req;
    logic wr;
    logic word;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic ack;
    logic busy;

    modport dev (input req, input wr, input word, input addr, input wdata,
                 output rdata, output ack, output busy);
    modport cpu (output req, output wr, output word, output addr, output wdata,
                 input rdata, input ack, input busy);
endinterface
`default_nettype wire

// File: src/flash_cmd_master.sv
// CPU-side master that issues flash reads and command sequences.
`timescale 1ns/10ps
`default_nettype none
module flash_cmd_master (
    input wire logic clock_i,
    input wire logic rst_i,
    flash_bus_if.cpu bus,
    input wire logic op_valid_i,
    input wire logic op_write_i,
    input wire logic [31:0] op_addr_i,
    input wire logic [15:0] op_data_i,
    output logic op_ready_o,
    output logic [31:0] rd_data_o,
    output logic rd_valid_o
);
    import flash_seq_pkg::*;

    typedef struct packed {
        logic busy;
        logic wr;
        logic [31:0] addr;
        logic [15:0] data;
        logic [31:0] rdat;
        logic rvld;
    } mst_t;

    mst_t s_q;
    mst_t s_d;

    // ------------------------------------------------------------
    // One access at a time; commands always go out as half-words.
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.rvld = 1'b0;
        if (!s_q.busy && op_valid_i) begin
            s_d.busy = 1'b1;
            s_d.wr = op_write_i;
            s_d.addr = op_addr_i;
            s_d.data = op_data_i;
        end else if (s_q.busy && bus.ack) begin
            s_d.busy = 1'b0;
            s_d.rdat = bus.rdata;
            s_d.rvld = ~s_q.wr;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Requests stay up until acknowledged.
    assign bus.req = s_q.busy;
    assign bus.wr = s_q.wr;
    assign bus.word = 1'b0;
    assign bus.addr = s_q.addr;
    assign bus.wdata = {16'h0000, s_q.data};
    assign op_ready_o = ~s_q.busy;
    assign rd_data_o = s_q.rdat;
    assign rd_valid_o = s_q.rvld;
endmodule
`default_nettype wire

// File: src/flash_cmd_seq.sv
// Flash command sequencer: access modes, command decoder, ECC array model.
`timescale 1ns/10ps
`default_nettype none
module flash_cmd_seq #(
    parameter int DEPTH_WORDS = 256,
    parameter int SECTORS = 8,
    parameter int SECT_WAIT = flash_seq_pkg::SECTOR_WAIT_CYC
) (
    input wire logic clock_i,
    input wire logic rst_i,
    flash_bus_if.dev bus,
    input wire logic [1:0] access_size_field_i,
    input wire logic access_size_wr_i,
    output logic [1:0] access_size_field_o,
    output logic prog_mode_o,
    output logic algo_busy_o,
    output logic [2:0] algo_state_o,
    input wire logic [31:0] flip_mask_i
);
    import flash_seq_pkg::*;

    localparam int AW = $clog2(DEPTH_WORDS);
    localparam int SW = $clog2(SECTORS);
    localparam int SECT_WORDS = DEPTH_WORDS / SECTORS;

    typedef struct packed {
        logic [1:0] acc_size;
        logic [2:0] step;
        logic erase_arm;
        alg_state_t alg;
        logic [12:0] cnt;
        logic [SECTORS-1:0] sect_sel;
        logic [AW-1:0] wcnt;
        logic [31:0] rdata;
        logic ack;
    } seq_t;

    seq_t s_q;
    seq_t s_d;
    logic [38:0] mem_q [DEPTH_WORDS];

    logic wr_hit;
    logic rd_hit;
    logic in_range;
    logic [7:0] code;
    logic [15:0] lo;
    logic [AW-1:0] widx;
    logic [SW-1:0] sidx;
    logic prog_fire;
    logic [31:0] rd_word;
    logic [31:0] prog_word;
    logic [38:0] rd_raw;

    // ------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------
    assign code = bus.wdata[7:0];
    assign lo = bus.addr[15:0];
    assign in_range = (bus.addr[31:16] >= FLASH_HI_FIRST) &&
                      (bus.addr[31:16] <= FLASH_HI_LAST);
    assign wr_hit = bus.req && !s_q.ack && bus.wr;
    assign rd_hit = bus.req && !s_q.ack && !bus.wr;
    assign widx = bus.addr[AW+1:2];
    assign sidx = SW'(widx / AW'(SECT_WORDS));
    assign rd_raw = mem_q[widx];
    // Correction is combinational on the read path so reads keep their timing.
    assign rd_word = ecc_fix(rd_raw[31:0] ^ flip_mask_i, rd_raw[38:32]);
    assign prog_word = bus.addr[1] ? {bus.wdata[15:0], rd_word[15:0]} :
                                     {rd_word[31:16], bus.wdata[15:0]};

    // ------------------------------------------------------------
    // Command decoder and embedded algorithm
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.ack = 1'b0;
        prog_fire = 1'b0;
        if (access_size_wr_i) begin
            s_d.acc_size = access_size_field_i;
        end
        if (rd_hit) begin
            s_d.ack = 1'b1;
            if (s_q.acc_size == SIZE_ROM) begin
                s_d.rdata = rd_word;
            end else if (!bus.word) begin
                s_d.rdata = bus.addr[1] ? {16'h0000, rd_word[31:16]} :
                                          {16'h0000, rd_word[15:0]};
            end else begin
                s_d.rdata = 32'h0000_0000;
            end
        end
        if (wr_hit) begin
            s_d.ack = 1'b1;
            s_d.step = 3'h0;
            s_d.erase_arm = s_q.erase_arm;
            if (s_q.acc_size != SIZE_PROG || bus.word || !in_range) begin
                s_d.erase_arm = 1'b0;
            end else if (code == CODE_RESET && s_q.alg == ALG_IDLE) begin
                s_d.erase_arm = 1'b0;
            end else if (code == CODE_SUSPEND) begin
                if (s_q.alg == ALG_SECT || s_q.alg == ALG_SECT_WAIT) begin
                    s_d.alg = ALG_SUSP;
                end
            end else if (code == CODE_RESUME && s_q.alg == ALG_SUSP) begin
                s_d.alg = ALG_SECT;
            end else if (code == CODE_SECTOR && s_q.alg == ALG_SECT_WAIT) begin
                s_d.sect_sel[sidx] = 1'b1;
                s_d.cnt = 13'(SECT_WAIT);
            end else if (s_q.alg == ALG_IDLE) begin
                unique case (s_q.step)
                    3'h0: if (lo == CMD_ADDR_A && code == CODE_UNLOCK1) s_d.step = 3'h1;
                    3'h1: if (lo == CMD_ADDR_B && code == CODE_UNLOCK2) s_d.step = 3'h2;
                    3'h2: if (lo == CMD_ADDR_A && code == CODE_PROGRAM) begin
                        s_d.step = 3'h3;
                        s_d.erase_arm = 1'b0;
                    end else if (lo == CMD_ADDR_A && code == CODE_ERASE) begin
                        s_d.step = 3'h0;
                        s_d.erase_arm = 1'b1;
                    end
                    3'h3: if (!bus.addr[0]) begin
                        prog_fire = 1'b1;
                        s_d.alg = ALG_PROGRAM;
                        s_d.cnt = 13'(ALGO_CYC);
                    end
                    default: s_d.step = 3'h0;
                endcase
                // The erase path reuses the unlock steps after the 80 code.
                if (s_q.erase_arm && s_q.step == 3'h2) begin
                    s_d.erase_arm = 1'b0;
                    s_d.step = 3'h0;
                    if (lo == CMD_ADDR_A && code == CODE_CHIP) begin
                        s_d.alg = ALG_CHIP;
                        s_d.cnt = 13'(ALGO_CYC);
                        s_d.wcnt = '0;
                    end else if (code == CODE_SECTOR) begin
                        s_d.alg = ALG_SECT_WAIT;
                        s_d.sect_sel = '0;
                        s_d.sect_sel[sidx] = 1'b1;
                        s_d.cnt = 13'(SECT_WAIT);
                    end
                end else if (s_q.erase_arm && s_q.step < 3'h2 && s_d.step == 3'h0) begin
                    s_d.erase_arm = 1'b0;
                end
            end
        end
        // Algorithm timers; suspension freezes the sector erase.
        if (s_q.alg != ALG_IDLE && s_q.alg != ALG_SUSP && s_d.alg == s_q.alg) begin
            if (s_q.cnt != 13'h0) begin
                s_d.cnt = s_q.cnt - 13'h1;
            end else if (s_q.alg == ALG_SECT_WAIT) begin
                s_d.alg = ALG_SECT;
                s_d.cnt = 13'(ALGO_CYC);
                s_d.wcnt = '0;
        end else if ((s_q.alg == ALG_SECT || s_q.alg == ALG_CHIP) &&
                         s_q.wcnt != AW'(DEPTH_WORDS - 1)) begin
                // Both erases sweep every word index; sector erase writes only words in sectors set in sect_sel.
                s_d.wcnt = s_q.wcnt + AW'(1);
            end else begin
                s_d.alg = ALG_IDLE;
            end
        end
    end

    // Reset always restores read-only word mode, whatever was set before.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= '{acc_size: SIZE_RESET, alg: ALG_IDLE, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Array: program overwrites the addressed half-word, erase sets words to ones
    // ------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (prog_fire) begin
            mem_q[widx] <= {ecc_gen(prog_word), prog_word};
        end else if (s_q.alg == ALG_CHIP) begin
            mem_q[s_q.wcnt] <= {ecc_gen(32'hffff_ffff), 32'hffff_ffff};
        end else if (s_q.alg == ALG_SECT &&
                     s_q.sect_sel[SW'(s_q.wcnt / AW'(SECT_WORDS))]) begin
            mem_q[s_q.wcnt] <= {ecc_gen(32'hffff_ffff), 32'hffff_ffff};
        end
    end

    assign bus.ack = s_q.ack;
    assign bus.rdata = s_q.rdata;
    assign bus.busy = (s_q.alg != ALG_IDLE);
    assign access_size_field_o = s_q.acc_size;
    assign prog_mode_o = (s_q.acc_size == SIZE_PROG);
    assign algo_busy_o = (s_q.alg != ALG_IDLE);
    assign algo_state_o = s_q.alg;
endmodule
`default_nettype wire

// File: testbench/flash_bus_assertions.sv
// Checker for the bus joining the command master and the sequencer.
`timescale 1ns/10ps
`default_nettype none
module flash_bus_assertions (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic req_i,
    input wire logic wr_i,
    input wire logic word_i,
    input wire logic [31:0] addr_i,
    input wire logic [31:0] rdata_i,
    input wire logic ack_i,
    input wire logic busy_i
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);

    // ----------------------------------------
    // Handshake timing
    // ----------------------------------------
    // A taken request is answered exactly one cycle later, with no extra
    // cycles for read correction.
    ack_one_cycle_a: assert property (req_i && !ack_i |=> ack_i)
        else $error("ack missing one cycle after a taken request");
    ack_single_pulse_a: assert property (ack_i |=> !ack_i)
        else $error("ack held longer than one cycle");
    ack_has_cause_a: assert property (ack_i |-> $past(req_i) && !$past(ack_i))
        else $error("ack without a pending request");
    req_drop_a: assert property (ack_i |=> !req_i)
        else $error("request not dropped after ack");
    req_hold_a: assert property (req_i && !ack_i |=> req_i && $stable(addr_i) && $stable(wr_i))
        else $error("request changed before ack");

    // ----------------------------------------
    // Access size and results
    // ----------------------------------------
    // Command writes must never go out as word accesses.
    cmd_half_word_a: assert property (req_i && wr_i |-> !word_i)
        else $error("write issued as a word access");
    rdata_hold_a: assert property ($changed(rdata_i) |-> ack_i)
        else $error("read data changed without an answer");
    // The algorithm starts in the very cycle that answers the write launching it.
    busy_start_a: assert property ($rose(busy_i) |-> ack_i && wr_i)
        else $error("algorithm started without a launching write");
endmodule
`default_nettype wire

// File: testbench/flash_command_sequencer_tb.sv
// Self-checking testbench joining the bus master and the sequencer.
`timescale 1ns/10ps
`default_nettype none
module flash_command_sequencer_tb;
    import flash_seq_pkg::*;
    localparam logic [31:0] cmd_a = {16'h0000, CMD_ADDR_A};
    localparam logic [31:0] cmd_b = {16'h0000, CMD_ADDR_B};
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic op_valid = 1'b0;
    logic op_write = 1'b0;
    logic [31:0] op_addr = 32'h0;
    logic [15:0] op_data = 16'h0;
    logic [1:0] size_val = 2'h2;
    logic size_wr = 1'b0;
    logic [31:0] flip = 32'h0;
    logic op_ready, rd_valid, prog_mode, algo_busy;
    logic [31:0] rd_data;
    logic [1:0] size_now;
    logic [2:0] algo_state;
    int bad_count = 0;
    int total_checks = 0;

    // ----------------------------------------
    // Design under test
    // ----------------------------------------
    flash_bus_if bus_if ();
    flash_cmd_master flash_cmd_master_inst (.clock_i(clock_i), .rst_i(rst_i), .bus(bus_if.cpu),
        .op_valid_i(op_valid), .op_write_i(op_write), .op_addr_i(op_addr),
        .op_data_i(op_data), .op_ready_o(op_ready), .rd_data_o(rd_data),
        .rd_valid_o(rd_valid));
    // The erase wait is shortened so the sector tests stay brief.
    flash_cmd_seq #(.SECT_WAIT(20)) flash_cmd_seq_inst (.clock_i(clock_i), .rst_i(rst_i),
        .bus(bus_if.dev), .access_size_field_i(size_val), .access_size_wr_i(size_wr),
        .access_size_field_o(size_now), .prog_mode_o(prog_mode), .algo_busy_o(algo_busy),
        .algo_state_o(algo_state), .flip_mask_i(flip));
    flash_bus_assertions flash_bus_assertions_inst (.clock_i(clock_i), .rst_i(rst_i),
        .req_i(bus_if.req), .wr_i(bus_if.wr), .word_i(bus_if.word), .addr_i(bus_if.addr),
        .rdata_i(bus_if.rdata), .ack_i(bus_if.ack), .busy_i(bus_if.busy));

    // Free-running 100 MHz clock.
    initial begin
        forever #5 clock_i = ~clock_i;
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // One access: hold the request until taken, then await its answer.
    task automatic op(input logic w, input logic [31:0] a, input logic [15:0] d);
        op_write <= w;
        op_addr <= a;
        op_data <= d;
        op_valid <= 1'b1;
        repeat (50) begin
            @(posedge clock_i);
            if (op_ready === 1'b1) break;
        end
        op_valid <= 1'b0;
        repeat (50) begin
            @(posedge clock_i);
            if ((w ? bus_if.ack : rd_valid) === 1'b1) break;
        end
        @(posedge clock_i);
    endtask

    // Unlock pair; the upper bytes carry junk the decoder must ignore.
    task automatic unl(input logic [15:0] hi);
        op(1'b1, {hi, CMD_ADDR_A}, {8'h3c, CODE_UNLOCK1});
        op(1'b1, {hi, CMD_ADDR_B}, {8'hc3, CODE_UNLOCK2});
    endtask

    // Every command write carries the upper address half of the target.
    task automatic prog(input logic [31:0] a, input logic [15:0] d);
        unl(a[31:16]);
        op(1'b1, {a[31:16], CMD_ADDR_A}, {8'h5a, CODE_PROGRAM});
        op(1'b1, a, d);
    endtask

    task automatic erase6(input logic [31:0] a, input logic [7:0] code);
        unl(16'h0000);
        op(1'b1, cmd_a, {8'h00, CODE_ERASE});
        unl(16'h0000);
        op(1'b1, a, {8'h00, code});
    endtask

    // Waits a bounded time for the algorithm to reach a state.
    task automatic wait_state(input logic [2:0] s);
        repeat (600) begin
            if (algo_state === s) break;
            @(posedge clock_i);
        end
    endtask

    task automatic size_set(input logic [1:0] v);
        size_val <= v;
        size_wr <= 1'b1;
        @(posedge clock_i);
        size_wr <= 1'b0;
        @(posedge clock_i);
    endtask

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        check(32'(size_now), 32'(SIZE_RESET));
        check(32'(prog_mode), 32'h0);
        prog(32'h100, 16'h1234);
        check(32'(algo_busy), 32'h0);
        size_set(SIZE_PROG);
        check(32'(prog_mode), 32'h1);
        erase6(cmd_a, CODE_CHIP);
        check(32'(algo_state), 32'(ALG_CHIP));
        wait_state(ALG_IDLE);
        prog(32'h100, 16'h1234);
        check(32'(algo_state), 32'(ALG_PROGRAM));
        op(1'b1, cmd_b, {8'h00, CODE_SUSPEND});
        check(32'(algo_state), 32'(ALG_PROGRAM));
        wait_state(ALG_IDLE);
        op(1'b0, 32'h100, 16'h0);
        check(32'(rd_data[15:0]), 32'h1234);
        flip <= 32'h0000_0010;
        op(1'b0, 32'h100, 16'h0);
        check(32'(rd_data[15:0]), 32'h1234);
        flip <= 32'h0;
        // Sequences aimed at the security and trimming areas run like any other.
        prog(SECURITY_BASE, 16'h00a5);
        check(32'(algo_state), 32'(ALG_PROGRAM));
        wait_state(ALG_IDLE);
        op(1'b0, SECURITY_BASE, 16'h0);
        check(rd_data, 32'h0000_00a5);
        prog(TRIM_BASE, 16'h005a);
        check(32'(algo_state), 32'(ALG_PROGRAM));
        wait_state(ALG_IDLE);
        // Program data sent to an odd address is not recognised.
        prog(32'h0000_0105, 16'h7777);
        check(32'(algo_busy), 32'h0);
        // Broken, out-of-range and reset sequences must start nothing.
        unl(16'h0000);
        op(1'b1, cmd_a, 16'h0077);
        op(1'b1, 32'h104, 16'h5555);
        check(32'(algo_busy), 32'h0);
        prog(32'h0020_0104, 16'h5555);
        check(32'(algo_busy), 32'h0);
        unl(16'h0000);
        op(1'b1, 32'h200, {8'h00, CODE_RESET});
        op(1'b1, cmd_a, {8'h00, CODE_PROGRAM});
        op(1'b1, 32'h104, 16'h5555);
        check(32'(algo_busy), 32'h0);
        // Sector erase gathers a second sector, then suspends and resumes.
        erase6(32'h200, CODE_SECTOR);
        check(32'(algo_state), 32'(ALG_SECT_WAIT));
        op(1'b1, 32'h300, {8'h00, CODE_SECTOR});
        check(32'(algo_state), 32'(ALG_SECT_WAIT));
        wait_state(ALG_SECT);
        op(1'b1, cmd_b, {8'h00, CODE_SUSPEND});
        check(32'(algo_state), 32'(ALG_SUSP));
        op(1'b0, 32'h100, 16'h0);
        check(32'(rd_data[15:0]), 32'h1234);
        op(1'b1, cmd_b, {8'h00, CODE_RESUME});
        check(32'(algo_state), 32'(ALG_SECT));
        wait_state(ALG_IDLE);
        // A reset from programming mode falls back to word reads.
        rst_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        check(32'(size_now), 32'(SIZE_RESET));
        check(32'(prog_mode), 32'h0);
        op(1'b0, 32'h100, 16'h0);
        check(rd_data, 32'hffff_1234);
        give_verdict();
    end

    // Watchdog far beyond the thousand or so cycles the tests need.
    initial begin
        repeat (20000) @(posedge clock_i);
        bad_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
